// file: hw/ltx_pkg.sv
package ltx_pkg;

  // apb register byte offsets
  localparam logic [11:0] LTX_CTRL_OFS = 12'h000;
  localparam logic [11:0] LTX_STATUS_OFS = 12'h004;
  localparam logic [11:0] LTX_ERRCNT_OFS = 12'h008;
  localparam logic [11:0] LTX_BPVCNT_OFS = 12'h00C;

  // control register fields
  localparam int LTX_CTRL_MODE_LSB = 0;
  localparam int LTX_CTRL_LOOP_BIT = 2;
  localparam logic [2:0] LTX_CTRL_RESET = 3'h0;

  // status register fields
  localparam int LTX_STAT_HOST_BIT = 0;
  localparam int LTX_STAT_TXCLK_BIT = 1;
  localparam int LTX_STAT_LOS_BIT = 2;
  localparam int LTX_STAT_MODE_LSB = 3;

  // transmit data mode codes
  localparam logic [1:0] LTX_MODE_BIPOLAR = 2'h0;
  localparam logic [1:0] LTX_MODE_UNIPOLAR = 2'h1;
  localparam logic [1:0] LTX_MODE_QRSS = 2'h2;

  // pattern generator: x^20 + x^17 + 1, nonzero seed
  localparam int LTX_PRBS_LEN = 20;
  localparam int LTX_PRBS_TAP = 17;
  localparam logic [19:0] LTX_PRBS_SEED = 20'hFFFFF;

  // timing: pclk period and transmit clock loss timeout
  localparam int LTX_PCLK_PERIOD_NS = 4;
  localparam int LTX_TXCLK_TIMEOUT_NS = 1000;
  localparam int LTX_TXCLK_TIMEOUT_CYC = LTX_TXCLK_TIMEOUT_NS / LTX_PCLK_PERIOD_NS;

  // synchroniser depth and strap capture point after reset release
  localparam int LTX_SYNC_STAGES = 2;
  localparam logic [1:0] LTX_STRAP_CAPTURE_CNT = 2'h2;

  // number of pin inputs that cross into pclk
  localparam int LTX_NUM_SYNC = 14;

endpackage : ltx_pkg

// file: hw/ltx_sync.sv
`timescale 1ns/100ps
`default_nettype none

// bank of two-stage synchronisers, one per input bit
module ltx_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // signals from outside the domain
  output logic [WIDTH-1:0] sync_out // synchronised copies
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      logic meta_q;
      logic stable_q;
      // first stage is read only by the second
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= async_in[gi];
          stable_q <= meta_q;
        end
      end
      assign sync_out[gi] = stable_q;
    end
  endgenerate

endmodule : ltx_sync

`default_nettype wire

// file: hw/ltx_front.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// R1: outside supplies master clock at 1.544 or 2.048 MHz for internal timing.
// R2: transmit clock, when present, runs at the line rate of the chosen standard.
// R3: under loss of signal, recovered receive clock is taken from the master clock.
// R4: transmit pair sampled on falling transmit clock, else falling master clock.
// R5: bipolar modes take each symbol as a positive and negative wire pair.
// R6: unipolar mode takes single-wire data sampled on falling transmit clock.
// R7: in pattern mode each rising edge on error input flips one pattern bit.
// R8: inserted error follows loopback path; error input sampled like the data.
// R9: violation input sampled like data; each rising edge inserts one violation. Code inserts it only on a mark, and never in bipolar mode.
// R10: in pattern mode a requested violation goes into the pattern stream.
// R11: strap low selects pin control, strap high selects host register control.
// R12: rising edges found by comparing consecutive samples; held high inserts once.
module ltx_front (
  input wire logic pclk, // system clock, 250 MHz
  input wire logic presetn, // async reset, active low
  input wire logic [11:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data
  output logic pslverr, // apb error on unmapped address
  input wire logic tx_line_clk, // transmit clock from the far side
  input wire logic mclk_in, // master reference clock pin
  input wire logic tx_pos_in, // positive transmit data / unipolar data
  input wire logic tx_neg_in, // negative transmit data
  input wire logic insert_bit_error_in, // pattern error insert request
  input wire logic insert_violation_in, // bipolar violation insert request
  input wire logic mode_strap_in, // control style strap
  input wire logic [1:0] hw_data_mode_in, // data mode pins under pin control
  input wire logic hw_loopback_in, // loopback pin under pin control
  input wire logic signal_lost, // loss of signal from the receiver
  input wire logic rx_line_clk_in, // clock recovered from the line
  input wire logic rx_pos_line_in, // received positive pulses
  input wire logic rx_neg_line_in, // received negative pulses
  output logic line_pos_out, // positive pulse toward the line driver
  output logic line_neg_out, // negative pulse toward the line driver
  output logic line_strobe_out, // one pclk pulse per new symbol
  output logic rx_clk_out, // recovered receive clock
  output logic rx_pos_out, // receive positive output
  output logic rx_neg_out // receive negative output
);

  // ---------------- link domain capture ----------------
  logic lk_pos_q;
  logic lk_neg_q;
  logic lk_err_q;
  logic lk_bpv_q;
  logic lk_tgl_q;

  // inputs caught on the falling transmit clock, held until the next edge
  always_ff @(negedge tx_line_clk or negedge presetn) begin
    if (!presetn) begin
      lk_pos_q <= 1'b0;
      lk_neg_q <= 1'b0;
      lk_err_q <= 1'b0;
      lk_bpv_q <= 1'b0;
      lk_tgl_q <= 1'b0;
    end else begin
      lk_pos_q <= tx_pos_in; // [R4] [R5] [R6]
      lk_neg_q <= tx_neg_in; // [R4] [R5]
      lk_err_q <= insert_bit_error_in; // [R8]
      lk_bpv_q <= insert_violation_in; // [R9]
      lk_tgl_q <= ~lk_tgl_q;
    end
  end

  // ---------------- pin synchronisers ----------------
  logic [ltx_pkg::LTX_NUM_SYNC-1:0] pins_raw;
  logic [ltx_pkg::LTX_NUM_SYNC-1:0] pins_s;

  assign pins_raw = {lk_tgl_q, tx_line_clk, mclk_in, tx_pos_in, tx_neg_in,
                     insert_bit_error_in, insert_violation_in, mode_strap_in,
                     hw_data_mode_in, hw_loopback_in, signal_lost,
                     rx_line_clk_in, rx_pos_line_in ^ rx_neg_line_in ^ rx_neg_line_in};

  ltx_sync #(
    .WIDTH(ltx_pkg::LTX_NUM_SYNC)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic rxneg_meta_q;
  logic rxneg_s_q;
  // receive negative pulse crosses on its own pair of stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxneg_meta_q <= 1'b0;
      rxneg_s_q <= 1'b0;
    end else begin
      rxneg_meta_q <= rx_neg_line_in;
      rxneg_s_q <= rxneg_meta_q;
    end
  end

  logic tgl_s;
  logic txclk_s;
  logic mclk_s;
  logic pos_s;
  logic neg_s;
  logic err_s;
  logic bpv_s;
  logic strap_s;
  logic [1:0] hwmode_s;
  logic hwloop_s;
  logic los_s;
  logic rxclk_s;
  logic rxpos_s;

  assign {tgl_s, txclk_s, mclk_s, pos_s, neg_s, err_s, bpv_s, strap_s,
          hwmode_s, hwloop_s, los_s, rxclk_s, rxpos_s} = pins_s;

  // ---------------- clock edge tracking ----------------
  logic tgl_d1_q;
  logic txclk_d1_q;
  logic mclk_d1_q;

  // previous synchronised values for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_d1_q <= 1'b0;
      txclk_d1_q <= 1'b0;
      mclk_d1_q <= 1'b0;
    end else begin
      tgl_d1_q <= tgl_s;
      txclk_d1_q <= txclk_s;
      mclk_d1_q <= mclk_s;
    end
  end

  logic link_evt;
  logic txclk_edge;
  logic mclk_fall;

  assign link_evt = tgl_s ^ tgl_d1_q;
  assign txclk_edge = txclk_s ^ txclk_d1_q;
  assign mclk_fall = mclk_d1_q & ~mclk_s;

  // transmit clock presence watchdog
  localparam logic [8:0] TXCLK_TIMEOUT = 9'(ltx_pkg::LTX_TXCLK_TIMEOUT_CYC);
  logic [8:0] txclk_cnt_q;
  logic txclk_present;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txclk_cnt_q <= 9'h000;
    end else if (txclk_edge) begin
      txclk_cnt_q <= TXCLK_TIMEOUT;
    end else if (txclk_cnt_q != 9'h000) begin
      txclk_cnt_q <= txclk_cnt_q - 9'h001;
    end
  end

  assign txclk_present = (txclk_cnt_q != 9'h000);

  // ---------------- strap capture ----------------
  logic [1:0] strap_cnt_q;
  logic host_mode_q;

  // strap taken once its synchroniser has filled after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q <= 2'h0;
      host_mode_q <= 1'b0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == ltx_pkg::LTX_STRAP_CAPTURE_CNT) begin
        host_mode_q <= strap_s; // [R11]
      end
    end
  end

  // ---------------- register file ----------------
  logic [2:0] ctrl_q;
  logic [15:0] errcnt_q;
  logic [15:0] bpvcnt_q;
  logic [31:0] prdata_q;
  logic [1:0] act_mode;
  logic act_loop;
  logic addr_hit;
  logic wr_en;

  // control source follows the strap
  assign act_mode = host_mode_q ? ctrl_q[ltx_pkg::LTX_CTRL_MODE_LSB +: 2] : hwmode_s; // [R11]
  assign act_loop = host_mode_q ? ctrl_q[ltx_pkg::LTX_CTRL_LOOP_BIT] : hwloop_s; // [R11]

  assign addr_hit = (paddr == ltx_pkg::LTX_CTRL_OFS) || (paddr == ltx_pkg::LTX_STATUS_OFS) ||
                    (paddr == ltx_pkg::LTX_ERRCNT_OFS) || (paddr == ltx_pkg::LTX_BPVCNT_OFS);
  assign wr_en = psel & penable & pwrite & (paddr == ltx_pkg::LTX_CTRL_OFS);

  // control register write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ltx_pkg::LTX_CTRL_RESET;
    end else if (wr_en) begin
      ctrl_q <= pwdata[2:0];
    end
  end

  logic [31:0] rd_mux;
  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      ltx_pkg::LTX_CTRL_OFS: rd_mux = {29'h0000_0000, ctrl_q};
      ltx_pkg::LTX_STATUS_OFS: begin
        rd_mux[ltx_pkg::LTX_STAT_HOST_BIT] = host_mode_q;
        rd_mux[ltx_pkg::LTX_STAT_TXCLK_BIT] = txclk_present;
        rd_mux[ltx_pkg::LTX_STAT_LOS_BIT] = los_s;
        rd_mux[ltx_pkg::LTX_STAT_MODE_LSB +: 2] = act_mode;
      end
      ltx_pkg::LTX_ERRCNT_OFS: rd_mux = {16'h0000, errcnt_q};
      ltx_pkg::LTX_BPVCNT_OFS: rd_mux = {16'h0000, bpvcnt_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // ---------------- symbol strobe and source select ----------------
  logic stb;
  logic s_pos;
  logic s_neg;
  logic s_err;
  logic s_bpv;

  // link capture when transmit clock runs, master clock fall otherwise
  assign stb = txclk_present ? link_evt : mclk_fall; // [R4] [R8] [R9]
  assign s_pos = txclk_present ? lk_pos_q : pos_s;
  assign s_neg = txclk_present ? lk_neg_q : neg_s;
  assign s_err = txclk_present ? lk_err_q : err_s;
  assign s_bpv = txclk_present ? lk_bpv_q : bpv_s;

  // previous sampled levels of the insert inputs
  logic err_prev_q;
  logic bpv_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_prev_q <= 1'b0;
      bpv_prev_q <= 1'b0;
    end else if (stb) begin
      err_prev_q <= s_err; // [R12]
      bpv_prev_q <= s_bpv; // [R12]
    end
  end

  logic err_rise;
  logic bpv_rise;

  assign err_rise = s_err & ~err_prev_q; // [R7] [R12]
  assign bpv_rise = s_bpv & ~bpv_prev_q; // [R9] [R12]

  // ---------------- pattern generator ----------------
  logic [ltx_pkg::LTX_PRBS_LEN-1:0] prbs_q;
  logic prbs_bit;
  logic is_qrss;
  logic is_bipolar;

  assign is_qrss = (act_mode == ltx_pkg::LTX_MODE_QRSS);
  assign is_bipolar = (act_mode == ltx_pkg::LTX_MODE_BIPOLAR);
  assign prbs_bit = prbs_q[ltx_pkg::LTX_PRBS_LEN-1] ^ prbs_q[ltx_pkg::LTX_PRBS_TAP-1];

  // lfsr advances once per symbol in pattern mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prbs_q <= ltx_pkg::LTX_PRBS_SEED;
    end else if (stb && is_qrss) begin
      prbs_q <= {prbs_q[ltx_pkg::LTX_PRBS_LEN-2:0], prbs_bit};
    end
  end

  // ---------------- symbol encoding ----------------
  logic mark;
  logic do_bpv;
  logic next_pol;
  logic enc_pos;
  logic enc_neg;
  logic last_pol_q;

  // unipolar bit, or pattern bit with one flipped bit per error request
  assign mark = is_qrss ? (prbs_bit ^ err_rise) : s_pos; // [R6] [R7]
  // violation lands on a pattern mark in pattern mode, on an external data mark in unipolar mode, never in bipolar mode
  assign do_bpv = ~is_bipolar & mark & bpv_rise; // [R9] [R10]
  assign next_pol = do_bpv ? last_pol_q : ~last_pol_q;

  always_comb begin
    enc_pos = 1'b0;
    enc_neg = 1'b0;
    if (is_bipolar) begin
      enc_pos = s_pos; // [R5]
      enc_neg = s_neg; // [R5]
    end else if (mark) begin
      enc_pos = next_pol;
      enc_neg = ~next_pol;
    end
  end

  // polarity of the last mark, for alternate mark inversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_pol_q <= 1'b0;
    end else if (stb && !is_bipolar && mark) begin
      last_pol_q <= next_pol;
    end
  end

  // transmit symbol register toward the line driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_pos_out <= 1'b0;
      line_neg_out <= 1'b0;
      line_strobe_out <= 1'b0;
    end else begin
      line_strobe_out <= stb;
      if (stb) begin
        line_pos_out <= enc_pos;
        line_neg_out <= enc_neg;
      end
    end
  end

  // insertion counters, wrap at full scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      errcnt_q <= 16'h0000;
      bpvcnt_q <= 16'h0000;
    end else if (stb) begin
      if (is_qrss && err_rise) begin
        errcnt_q <= errcnt_q + 16'h0001; // [R7]
      end
      if (do_bpv) begin
        bpvcnt_q <= bpvcnt_q + 16'h0001; // [R9]
      end
    end
  end

  // ---------------- receive side ----------------
  // local loopback carries the transmitted symbol, error included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pos_out <= 1'b0;
      rx_neg_out <= 1'b0;
    end else if (act_loop) begin
      if (stb) begin
        rx_pos_out <= enc_pos; // [R8]
        rx_neg_out <= enc_neg; // [R8]
      end
    end else begin
      rx_pos_out <= rxpos_s;
      rx_neg_out <= rxneg_s_q;
    end
  end

  // recovered clock falls back to the master clock on loss of signal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_clk_out <= 1'b0;
    end else begin
      rx_clk_out <= los_s ? mclk_s : rxclk_s; // [R3] [R1]
    end
  end

endmodule : ltx_front

`default_nettype wire

// file: testbench/ltx_front_checker.sv
`timescale 1ns/100ps
`default_nettype none

// watches transmit sampling, line coding and receive clock choice
module ltx_front_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic tx_line_clk, // tx clock
  input wire logic mclk_in, // master clock
  input wire logic tx_pos_in, // data
  input wire logic tx_neg_in, // data
  input wire logic insert_violation_in, // request
  input wire logic mode_strap_in, // strap
  input wire logic [1:0] hw_data_mode_in, // mode pins
  input wire logic hw_loopback_in, // loop pin
  input wire logic signal_lost, // los
  input wire logic rx_line_clk_in, // line clock
  input wire logic line_pos_out, // symbol
  input wire logic line_neg_out, // symbol
  input wire logic line_strobe_out, // strobe
  input wire logic rx_clk_out, // rx clock
  input wire logic rx_pos_out, // rx data
  input wire logic rx_neg_out // rx data
);
  logic [1:0] cnt_q;
  logic [5:0] idle_q;
  logic [3:0] calm_q;
  logic [3:0] cfg_q;
  logic pcap_q, ncap_q, vcap_q, vprev_q, lastp_q, have_q, ok, uni;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pin-control mode settled for a while
  assign ok = !mode_strap_in && calm_q == 4'hF;
  assign uni = ok && hw_data_mode_in == ltx_pkg::LTX_MODE_UNIPOLAR;

  // counts transmit clock falls, forgets them after a long pause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      idle_q <= 6'h0;
    end else if ($fell(tx_line_clk)) begin
      idle_q <= 6'h0;
      if (cnt_q != 2'h2) cnt_q <= cnt_q + 2'h1;
    end else if (idle_q == 6'h28) begin
      cnt_q <= 2'h0;
    end else begin
      idle_q <= idle_q + 6'h1;
    end
  end

  // inputs as seen at each transmit clock fall
  always_ff @(posedge pclk) begin
    if ($fell(tx_line_clk)) begin
      pcap_q <= tx_pos_in;
      ncap_q <= tx_neg_in;
      vcap_q <= insert_violation_in;
      vprev_q <= vcap_q;
    end
  end

  // settle counter over the configuration pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 4'h0;
      calm_q <= 4'h0;
    end else begin
      cfg_q <= {mode_strap_in, hw_data_mode_in, hw_loopback_in};
      if (cfg_q != {mode_strap_in, hw_data_mode_in, hw_loopback_in}) calm_q <= 4'h0;
      else if (calm_q != 4'hF) calm_q <= calm_q + 4'h1;
    end
  end

  // polarity of the last mark sent in unipolar mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      have_q <= 1'b0;
      lastp_q <= 1'b0;
    end else if (!uni) begin
      have_q <= 1'b0;
    end else if (line_strobe_out && (line_pos_out || line_neg_out)) begin
      have_q <= 1'b1;
      lastp_q <= line_pos_out;
    end
  end

  sequence s_fall_seen;
    $fell(tx_line_clk) && cnt_q != 2'h0;
  endsequence

  sequence s_tx_symbol;
    line_strobe_out && cnt_q == 2'h2;
  endsequence

  a_fall_strobe: assert property (s_fall_seen |-> ##[2:6] line_strobe_out)
    else $error("no strobe after transmit clock fall");
  a_strobe_pulse: assert property (line_strobe_out |=> !line_strobe_out)
    else $error("strobe longer than one cycle");
  a_bipolar_pair: assert property (s_tx_symbol ##0 ok && hw_data_mode_in == 2'h0
    |-> line_pos_out == pcap_q && line_neg_out == ncap_q) else $error("pair not passed");
  a_unipolar_ami: assert property (s_tx_symbol ##0 uni
    |-> (line_pos_out | line_neg_out) == pcap_q && !(line_pos_out && line_neg_out))
    else $error("unipolar symbol wrong");
  a_violation_once: assert property (s_tx_symbol ##0 uni && have_q && pcap_q
    |-> line_pos_out == ((vcap_q && !vprev_q) ? lastp_q : !lastp_q))
    else $error("mark polarity wrong");
  a_loop_echo: assert property (line_strobe_out && ok && hw_loopback_in
    |-> rx_pos_out == line_pos_out && rx_neg_out == line_neg_out) else $error("no echo");
  a_lost_mclk: assert property (signal_lost [*6] ##0 $past(mclk_in, 2) == $past(mclk_in, 4)
    |-> rx_clk_out == $past(mclk_in, 3)) else $error("rx clock not from master clock");
  a_line_rclk: assert property ((!signal_lost) [*6] ##0
    $past(rx_line_clk_in, 2) == $past(rx_line_clk_in, 4)
    |-> rx_clk_out == $past(rx_line_clk_in, 3)) else $error("rx clock not from line");
endmodule : ltx_front_checker

bind ltx_front ltx_front_checker u_ltx_front_checker (.*);

`default_nettype wire

// file: testbench/ltx_far_model.sv
`timescale 1ns/100ps
`default_nettype none

// framer side: transmit clock and data
module ltx_far_model (
  input wire logic run, // clock runs while high
  input wire logic ones, // marks only
  output logic tx_line_clk, // tx clock
  output logic tx_pos_in, // positive data
  output logic tx_neg_in // negative data
);
  logic [2:0] sym_q;

  // 8 MHz transmit clock (125 ns period), still while stopped
  initial begin
    tx_line_clk = 1'b0;
    sym_q = 3'h0;
    tx_pos_in = 1'b0;
    tx_neg_in = 1'b0;
    #37.3;
    forever begin
      if (run) begin
        #62.5 tx_line_clk = 1'b1;
        #62.5 tx_line_clk = 1'b0;
      end else begin
        #5;
      end
    end
  end

  // new symbol after each rise; never both wires
  always @(posedge tx_line_clk) begin
    sym_q <= sym_q + 3'h1;
    tx_pos_in <= ones | sym_q[0];
    tx_neg_in <= !ones & !sym_q[0] & sym_q[1];
  end
endmodule : ltx_far_model

`default_nettype wire

// file: testbench/ltx_front_tb.sv
`timescale 1ns/100ps
`default_nettype none

// front end driven over apb and by the framer model
module ltx_front_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, run, ones;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic tx_line_clk, mclk_in, tx_pos_in, tx_neg_in, insert_bit_error_in, insert_violation_in;
  logic mode_strap_in, hw_loopback_in, signal_lost, rx_line_clk_in, rx_pos_line_in, rx_neg_line_in;
  logic [1:0] hw_data_mode_in;
  logic line_pos_out, line_neg_out, line_strobe_out, rx_clk_out, rx_pos_out, rx_neg_out;
  int n_mismatch, tests_run, cyc, nstb, n0;

  ltx_front u_ltx_front (.*);
  ltx_far_model u_ltx_far_model (.run(run), .ones(ones), .tx_line_clk(tx_line_clk),
    .tx_pos_in(tx_pos_in), .tx_neg_in(tx_neg_in));

  // system, master and received line clocks
  always #2 pclk = ~pclk;
  always #244.14 mclk_in = ~mclk_in;
  always #323.8 rx_line_clk_in = ~rx_line_clk_in;

  // strobe count and cycle ceiling
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (line_strobe_out === 1'b1) nstb <= nstb + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask : rd

  function automatic logic [31:0] st(input logic h, t, l, input logic [1:0] m);
    st = {27'h0, m, l, t, h};
  endfunction : st

  task automatic sym(input int n);
    repeat (n * 32) @(posedge pclk);
  endtask : sym

  task automatic pulse(input logic e, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (e) insert_bit_error_in <= 1'b1;
      else insert_violation_in <= 1'b1;
      sym(3);
      insert_bit_error_in <= 1'b0;
      insert_violation_in <= 1'b0;
      sym(3);
    end
  endtask : pulse

  task automatic reset_dut(input logic strap);
    presetn <= 1'b0;
    mode_strap_in <= strap;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : reset_dut

  // main sequence
  initial begin
    {pclk, mclk_in, rx_line_clk_in, presetn, psel, penable, pwrite} = 7'h0;
    {insert_bit_error_in, insert_violation_in, mode_strap_in, hw_loopback_in} = 4'h0;
    {signal_lost, rx_pos_line_in, rx_neg_line_in, run, ones} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hw_data_mode_in = ltx_pkg::LTX_MODE_BIPOLAR;
    {n_mismatch, tests_run, cyc, nstb} = {32'h0, 32'h0, 32'h0, 32'h0};
    reset_dut(1'b0);
    rd(ltx_pkg::LTX_CTRL_OFS, {29'h0, ltx_pkg::LTX_CTRL_RESET});
    run <= 1'b1;
    sym(20);
    rd(ltx_pkg::LTX_STATUS_OFS, st(1'b0, 1'b1, 1'b0, 2'h0));
    $display("test bipolar done");
    hw_data_mode_in <= ltx_pkg::LTX_MODE_UNIPOLAR;
    ones <= 1'b1; // marks settled before the first violation request
    sym(12);
    pulse(1'b0, 2);
    rd(ltx_pkg::LTX_BPVCNT_OFS, 32'h2);
    pulse(1'b1, 1);
    rd(ltx_pkg::LTX_ERRCNT_OFS, 32'h0);
    $display("test unipolar done");
    hw_loopback_in <= 1'b1;
    signal_lost <= 1'b1;
    sym(10);
    rd(ltx_pkg::LTX_STATUS_OFS, st(1'b0, 1'b1, 1'b1, 2'h1));
    signal_lost <= 1'b0;
    hw_loopback_in <= 1'b0;
    // loopback off: receive outputs follow the line pins
    rx_pos_line_in <= 1'b1;
    sym(1);
    chk({30'h0, rx_pos_out, rx_neg_out}, 32'h2);
    rx_neg_line_in <= 1'b1;
    sym(1);
    chk({30'h0, rx_pos_out, rx_neg_out}, 32'h3);
    $display("test loopback done");
    run <= 1'b0;
    sym(12);
    n0 = nstb;
    sym(20);
    chk({31'h0, nstb > n0}, 32'h1);
    rd(ltx_pkg::LTX_STATUS_OFS, st(1'b0, 1'b0, 1'b0, 2'h1));
    run <= 1'b1;
    $display("test master clock fallback done");
    reset_dut(1'b1);
    sym(3);
    rd(ltx_pkg::LTX_STATUS_OFS, st(1'b1, 1'b1, 1'b0, 2'h0));
    apb(1'b1, ltx_pkg::LTX_CTRL_OFS, {30'h0, ltx_pkg::LTX_MODE_QRSS});
    apb(1'b1, ltx_pkg::LTX_STATUS_OFS, 32'hFFFFFFFF);
    rd(ltx_pkg::LTX_STATUS_OFS, st(1'b1, 1'b1, 1'b0, 2'h2));
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    chk(rd_q, 32'h0);
    pulse(1'b1, 2);
    rd(ltx_pkg::LTX_ERRCNT_OFS, 32'h2);
    // host loopback: receive outputs echo the pattern symbols, not the line pins
    apb(1'b1, ltx_pkg::LTX_CTRL_OFS, {29'h0, 1'b1, ltx_pkg::LTX_MODE_QRSS});
    @(posedge pclk);
    repeat (3) begin
      @(posedge pclk iff line_strobe_out === 1'b1);
      chk({30'h0, rx_pos_out, rx_neg_out}, {30'h0, line_pos_out, line_neg_out});
    end
    pulse(1'b0, 8);
    apb(1'b0, ltx_pkg::LTX_BPVCNT_OFS, 32'h0);
    chk({31'h0, rd_q != 32'h0 && rd_q <= 32'h8}, 32'h1);
    $display("test host pattern done");
    end_of_test();
  end
endmodule : ltx_front_tb

`default_nettype wire
